// ### dct_pkg.sv
// Purpose: shared constants for the dma channel run and termination block
// Assumes: one system clock, asynchronous active-high reset
// Notes: field positions of the mode and status words live here
`default_nettype none
package dct_pkg;
	// ==========================================================
	// mode word fields
	localparam int MODE_W = 6;
	localparam int MODE_RUN_BIT = 0;
	localparam int MODE_INTERNAL_BIT = 1;
	localparam int MODE_NIRQ_BIT = 2;
	localparam int MODE_EIRQ_BIT = 3;
	localparam int MODE_SRC_INC_BIT = 4;
	localparam int MODE_DST_INC_BIT = 5;
	localparam logic [MODE_W-1:0] MODE_RESET = 6'h00;
	// ==========================================================
	// status word fields
	localparam int STAT_W = 4;
	localparam int STAT_NORMAL_BIT = 0;
	localparam int STAT_EXT_BIT = 1;
	localparam int STAT_DEST_ERR_BIT = 2;
	localparam int STAT_SRC_ERR_BIT = 3;
	localparam logic [STAT_W-1:0] STAT_RESET = 4'h0;
	// ==========================================================
	// parameter register select and function codes
	localparam int SEL_W = 2;
	localparam logic [SEL_W-1:0] SEL_SRC = 2'h0;
	localparam logic [SEL_W-1:0] SEL_DST = 2'h1;
	localparam logic [SEL_W-1:0] SEL_FC = 2'h2;
	localparam logic [SEL_W-1:0] SEL_COUNT = 2'h3;
	localparam int FC_W = 3;
	localparam logic [2*FC_W-1:0] FC_RESET = 6'h2d;
	// ==========================================================
	// channel sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ARB = 2'h1,
		ST_READ = 2'h2,
		ST_WRITE = 2'h3
	} dct_state_type;
endpackage
`default_nettype wire

// ### dct_sync.sv
// Purpose: three-flop synchroniser for an outside pin
// Assumes: input is asynchronous to clock_in
// Notes: output changes only when the second and third flops agree
`timescale 1ns/1ps
`default_nettype none
module dct_sync (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic pin_in,
	output logic level_out
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic level_reg;
	wire agree = (s2_reg == s3_reg);
	// ==========================================================
	// sampling chain
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			level_reg <= 1'b0;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (agree) begin
				level_reg <= s3_reg;
			end
		end
	end
	assign level_out = level_reg;
endmodule
`default_nettype wire

// ### dct_fifo.sv
// Purpose: operand buffer between source read and destination write
// Assumes: depth is a power of two
// Notes: head word is held in an output register
`timescale 1ns/1ps
`default_nettype none
module dct_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0] used_reg;
	logic out_valid_reg;
	logic [WIDTH-1:0] out_data_reg;
	wire push = in_valid_in && in_ready_out;
	wire load = (!out_valid_reg || out_ready_in) && (used_reg != '0);
	// ==========================================================
	// storage and pointers
	assign in_ready_out = (used_reg != (PW+1)'(DEPTH));
	always_ff @(posedge clock_in) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_in;
		end
	end
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			used_reg <= '0;
			out_valid_reg <= 1'b0;
			out_data_reg <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + PW'(push);
			rd_ptr_reg <= rd_ptr_reg + PW'(load);
			used_reg <= used_reg + (PW+1)'(push) - (PW+1)'(load);
			if (load) begin
				out_data_reg <= mem_reg[rd_ptr_reg];
				out_valid_reg <= 1'b1;
			end else if (out_ready_in) begin
				out_valid_reg <= 1'b0;
			end
		end
	end
	assign out_valid_out = out_valid_reg;
	assign out_data_out = out_data_reg;
endmodule
`default_nettype wire

// ### dct_channel.sv
// Purpose: one dma channel, its run bit, requests and termination
// Assumes: bus grant stays high until the channel drops its request
// Notes: each operand is a source read then a destination write
// Behaviour
// RQ1: termination pin seen at a device access ends channel after that operand
// RQ2: external end clears run bit; interrupt only with normal enable
// RQ3: externally ended last operand still updates count and pointers
// RQ4: termination pin works for internal and external request modes
// RQ5: bus error aborts the cycle and ends the channel, clearing run bit
// RQ6: bus error sets destination or source error flag; interrupt if enabled
// RQ7: software loads parameters first, then sets the run bit
// RQ8: while running, pointers, function codes and count ignore writes
// RQ9: running channel uses request pin externally or self requests internally
// RQ10: first valid request makes the channel arbitrate for the bus
// RQ11: request pin is ignored while the run bit is clear
// RQ12: run bit clears itself on count zero, termination pin or bus error
// RQ13: clearing run bit finishes the operand, frees bus, starts nothing
// RQ14: suspended channel registers are readable and writable
// RQ15: run bit set again with request pending re-arbitrates and continues
// RQ16: mode word has separate normal and error interrupt enables
// RQ17: with enable clear only the status bit is set
// RQ18: enabled event pulses the pending set line to the interrupt block
// RQ19: every owned bus cycle drives a function code
// RQ20: source read error sets source flag, write error sets destination flag
// RQ21: count reaching zero sets normal status, interrupt only if enabled
`timescale 1ns/1ps
`default_nettype none
module dct_channel #(
	parameter int ADDR_W = 24,
	parameter int DATA_W = 16,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic cfg_write_in,
	input wire logic [dct_pkg::SEL_W-1:0] cfg_sel_in,
	input wire logic [ADDR_W-1:0] cfg_data_in,
	input wire logic mode_write_in,
	input wire logic [dct_pkg::MODE_W-1:0] mode_data_in,
	input wire logic [dct_pkg::STAT_W-1:0] status_clear_in,
	input wire logic xfer_request_in,
	input wire logic done_in,
	output logic xfer_acknowledge_out,
	output logic bus_request_out,
	input wire logic bus_grant_in,
	output logic bus_strobe_out,
	output logic bus_write_out,
	output logic [ADDR_W-1:0] bus_addr_out,
	output logic [DATA_W-1:0] bus_wdata_out,
	input wire logic [DATA_W-1:0] bus_rdata_in,
	input wire logic data_transfer_ack,
	input wire logic bus_error_in,
	output logic [dct_pkg::FC_W-1:0] bus_function_code_out,
	output logic [dct_pkg::MODE_W-1:0] channel_mode_out,
	output logic [dct_pkg::STAT_W-1:0] channel_status_out,
	output logic [ADDR_W-1:0] source_pointer_out,
	output logic [ADDR_W-1:0] dest_pointer_out,
	output logic [2*dct_pkg::FC_W-1:0] func_code_out,
	output logic [ADDR_W-1:0] byte_count_out,
	output logic irq_pending_set_out
);
	import dct_pkg::*;
	localparam logic [ADDR_W-1:0] STEP = ADDR_W'(DATA_W / 8);

	dct_state_type state_reg;
	dct_state_type state_next;
	logic [MODE_W-1:0] channel_mode_reg;
	logic [MODE_W-1:0] channel_mode_next;
	logic [STAT_W-1:0] channel_status_reg;
	logic [STAT_W-1:0] stat_set;
	logic [ADDR_W-1:0] source_pointer_reg;
	logic [ADDR_W-1:0] dest_pointer_reg;
	logic [ADDR_W-1:0] byte_count_reg;
	logic [2*FC_W-1:0] func_code_reg;
	logic term_seen_reg;
	logic irq_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic write_reg;
	logic [FC_W-1:0] fc_reg;
	logic req_sync;
	logic done_sync;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [DATA_W-1:0] fifo_out_data;

	// ==========================================================
	// pin synchronisers and operand buffer
	dct_sync u_req_sync (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.pin_in(xfer_request_in),
		.level_out(req_sync)
	);
	dct_sync u_done_sync (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.pin_in(done_in),
		.level_out(done_sync)
	);
	wire rd_ack = bus_strobe_out && (state_reg == ST_READ)
		&& data_transfer_ack && !bus_error_in;
	wire wr_ack = bus_strobe_out && (state_reg == ST_WRITE)
		&& data_transfer_ack && !bus_error_in;
	// a failed write drops its word so no stale operand survives the abort
	wire wr_drop = bus_strobe_out && (state_reg == ST_WRITE)
		&& bus_error_in; // [RQ5]
	wire fifo_pop = wr_ack || wr_drop;
	dct_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.in_valid_in(rd_ack),
		.in_ready_out(fifo_in_ready),
		.in_data_in(bus_rdata_in),
		.out_valid_out(fifo_out_valid),
		.out_ready_in(fifo_pop),
		.out_data_out(fifo_out_data)
	);

	// ==========================================================
	// decode
	wire run_bit = channel_mode_reg[MODE_RUN_BIT];
	wire internal_mode = channel_mode_reg[MODE_INTERNAL_BIT];
	wire normal_irq_enable = channel_mode_reg[MODE_NIRQ_BIT]; // [RQ16]
	wire error_irq_enable = channel_mode_reg[MODE_EIRQ_BIT]; // [RQ16]
	wire in_cycle = (state_reg == ST_READ) || (state_reg == ST_WRITE);
	wire err_now = bus_strobe_out && in_cycle && bus_error_in; // [RQ5]
	wire ext_term = term_seen_reg || done_sync; // [RQ1] [RQ4]
	wire last_operand = (byte_count_reg <= STEP);
	wire end_now = err_now || (wr_ack && (last_operand || ext_term));
	wire pending = internal_mode || req_sync; // [RQ9]
	wire can_start = run_bit && pending && (byte_count_reg != '0);
	wire cfg_open = cfg_write_in && !run_bit; // [RQ8] [RQ14]
	wire [ADDR_W-1:0] count_dec = last_operand ? '0
		: byte_count_reg - STEP;

	// ==========================================================
	// sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (can_start) begin
					state_next = ST_ARB; // [RQ10] [RQ11] [RQ15]
				end
			end
			ST_ARB: begin
				if (!run_bit) begin
					state_next = ST_IDLE; // [RQ13]
				end else if (bus_grant_in) begin
					state_next = ST_READ;
				end
			end
			ST_READ: begin
				if (err_now) begin
					state_next = ST_IDLE;
				end else if (rd_ack) begin
					state_next = ST_WRITE;
				end
			end
			ST_WRITE: begin
				if (err_now || wr_ack) begin
					state_next = ST_IDLE; // [RQ13]
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// mode, status and interrupt
	always_comb begin
		channel_mode_next = mode_write_in ? mode_data_in : channel_mode_reg;
		if (end_now) begin
			channel_mode_next[MODE_RUN_BIT] = 1'b0; // [RQ2] [RQ5] [RQ12]
		end
	end
	assign stat_set[STAT_NORMAL_BIT] = wr_ack && last_operand && !ext_term; // [RQ21]
	assign stat_set[STAT_EXT_BIT] = wr_ack && ext_term; // [RQ1]
	assign stat_set[STAT_DEST_ERR_BIT] = err_now
		&& (state_reg == ST_WRITE); // [RQ6] [RQ20]
	assign stat_set[STAT_SRC_ERR_BIT] = err_now
		&& (state_reg == ST_READ); // [RQ6] [RQ20]
	wire irq_next = ((stat_set[STAT_NORMAL_BIT] || stat_set[STAT_EXT_BIT])
		&& normal_irq_enable) || ((stat_set[STAT_DEST_ERR_BIT]
		|| stat_set[STAT_SRC_ERR_BIT]) && error_irq_enable); // [RQ17] [RQ18]

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= ST_IDLE;
			channel_mode_reg <= MODE_RESET;
			channel_status_reg <= STAT_RESET;
			irq_reg <= 1'b0;
			term_seen_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			channel_mode_reg <= channel_mode_next;
			channel_status_reg <= (channel_status_reg & ~status_clear_in)
				| stat_set;
			irq_reg <= irq_next;
			if (state_reg == ST_IDLE) begin
				term_seen_reg <= 1'b0;
			end else if (rd_ack && done_sync) begin
				term_seen_reg <= 1'b1; // [RQ1] [RQ4]
			end
		end
	end

	// ==========================================================
	// parameter registers
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			source_pointer_reg <= '0;
			dest_pointer_reg <= '0;
			byte_count_reg <= '0;
			func_code_reg <= FC_RESET;
		end else if (wr_ack) begin
			byte_count_reg <= count_dec; // [RQ3]
			if (channel_mode_reg[MODE_SRC_INC_BIT]) begin
				source_pointer_reg <= source_pointer_reg + STEP; // [RQ3]
			end
			if (channel_mode_reg[MODE_DST_INC_BIT]) begin
				dest_pointer_reg <= dest_pointer_reg + STEP; // [RQ3]
			end
		end else if (cfg_open) begin
			case (cfg_sel_in)
				SEL_SRC: source_pointer_reg <= cfg_data_in;
				SEL_DST: dest_pointer_reg <= cfg_data_in;
				SEL_FC: func_code_reg <= cfg_data_in[2*FC_W-1:0];
				SEL_COUNT: byte_count_reg <= cfg_data_in;
				default: byte_count_reg <= byte_count_reg;
			endcase
		end
	end

	// ==========================================================
	// bus drive
	wire next_write = (state_next == ST_WRITE);
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			addr_reg <= '0;
			write_reg <= 1'b0;
			fc_reg <= '0;
		end else begin
			addr_reg <= next_write ? dest_pointer_reg : source_pointer_reg;
			write_reg <= next_write;
			fc_reg <= next_write ? func_code_reg[FC_W-1:0]
				: func_code_reg[2*FC_W-1:FC_W]; // [RQ19]
		end
	end
	assign bus_request_out = (state_reg != ST_IDLE);
	assign bus_strobe_out = ((state_reg == ST_READ) && fifo_in_ready)
		|| ((state_reg == ST_WRITE) && fifo_out_valid);
	assign xfer_acknowledge_out = bus_strobe_out && !internal_mode;
	assign bus_write_out = write_reg;
	assign bus_addr_out = addr_reg;
	assign bus_wdata_out = fifo_out_data;
	assign bus_function_code_out = fc_reg;
	assign channel_mode_out = channel_mode_reg;
	assign channel_status_out = channel_status_reg;
	assign source_pointer_out = source_pointer_reg;
	assign dest_pointer_out = dest_pointer_reg;
	assign func_code_out = func_code_reg;
	assign byte_count_out = byte_count_reg;
	assign irq_pending_set_out = irq_reg;

	// ==========================================================
	// checks
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);
	sequence s_grant;
		(state_reg == ST_ARB) && run_bit && bus_grant_in;
	endsequence
	sequence s_write_done;
		wr_ack && !mode_write_in;
	endsequence
	a_ext_term_end: assert property (s_write_done and ext_term
		|=> !run_bit && channel_status_reg[STAT_EXT_BIT]) // [RQ1] [RQ2]
		else $error("external termination did not end channel");
	a_count_on_ack: assert property (wr_ack && byte_count_reg > STEP
		|=> byte_count_reg == $past(byte_count_reg) - STEP) // [RQ3]
		else $error("byte count not decremented");
	a_error_stops: assert property (err_now && !mode_write_in
		|=> !run_bit && state_reg == ST_IDLE) // [RQ5] [RQ12]
		else $error("bus error did not stop channel");
	a_error_flag_src: assert property (err_now && state_reg == ST_READ
		|=> channel_status_reg[STAT_SRC_ERR_BIT]
		&& !$rose(channel_status_reg[STAT_DEST_ERR_BIT])) // [RQ6] [RQ20]
		else $error("source error flag wrong");
	a_error_flag_dest: assert property (err_now && state_reg == ST_WRITE
		|=> channel_status_reg[STAT_DEST_ERR_BIT]
		&& !$rose(channel_status_reg[STAT_SRC_ERR_BIT])) // [RQ6] [RQ20]
		else $error("destination error flag wrong");
	a_params_locked: assert property (run_bit && cfg_write_in && !wr_ack
		|=> $stable(source_pointer_reg) && $stable(dest_pointer_reg)
		&& $stable(func_code_reg) && $stable(byte_count_reg)) // [RQ8]
		else $error("parameter changed while running");
	a_internal_start: assert property ((state_reg == ST_IDLE) && run_bit
		&& internal_mode && byte_count_reg != '0
		|=> state_reg == ST_ARB) // [RQ9]
		else $error("internal mode did not request bus");
	a_grant_to_read: assert property (s_grant
		|=> state_reg == ST_READ && !bus_write_out) // [RQ10]
		else $error("grant did not start source read");
	a_stopped_idle: assert property ((state_reg == ST_IDLE) && !run_bit
		&& !mode_write_in |=> state_reg == ST_IDLE ##0 !bus_request_out) // [RQ11] [RQ13]
		else $error("channel left idle with run bit clear");
	a_normal_end: assert property (s_write_done and (last_operand && !ext_term)
		|=> !run_bit && channel_status_reg[STAT_NORMAL_BIT]) // [RQ12] [RQ21]
		else $error("count exhaustion did not end channel");
	a_irq_gated: assert property (stat_set != '0 && !normal_irq_enable
		&& !error_irq_enable |=> !irq_pending_set_out) // [RQ17]
		else $error("interrupt raised with enables clear");
	a_irq_error: assert property (err_now && error_irq_enable
		|=> irq_pending_set_out ##1 !irq_pending_set_out) // [RQ18]
		else $error("error interrupt pulse missing");
	a_fc_driven: assert property (bus_strobe_out |-> bus_function_code_out
		== (bus_write_out ? func_code_reg[FC_W-1:0]
		: func_code_reg[2*FC_W-1:FC_W])) // [RQ19]
		else $error("function code wrong on bus cycle");
endmodule
`default_nettype wire

// ### dct_bus_model.sv
// Purpose: bus slave and arbiter model at the far side of the channel
// Assumes: one clock, grant follows request one cycle later
// Notes: wait states and error replies are chosen by the bench
`timescale 1ns/1ps
`default_nettype none
module dct_bus_model #(
	parameter int ADDR_W = 24,
	parameter int DATA_W = 16
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [3:0] wait_in,
	input wire logic fail_read_in,
	input wire logic fail_write_in,
	input wire logic bus_request_in,
	output logic bus_grant_out,
	input wire logic strobe_in,
	input wire logic write_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wdata_in,
	output logic [DATA_W-1:0] rdata_out,
	output logic ack_out,
	output logic error_out,
	output logic [ADDR_W-1:0] last_waddr_out,
	output logic [DATA_W-1:0] last_wdata_out,
	output logic [7:0] writes_out
);
	logic [3:0] wait_reg;
	logic [DATA_W-1:0] word;
	logic fail;
	logic done_cycle;
	// ==========================================================
	// reply decode
	assign word = addr_in[DATA_W-1:0] ^ DATA_W'(16'ha5c3);
	assign fail = write_in ? fail_write_in : fail_read_in;
	assign done_cycle = strobe_in && !ack_out && !error_out &&
		wait_reg == wait_in;
	// released data lines show the inverse, never a stale copy
	assign rdata_out = ack_out ? word : ~word;
	// ==========================================================
	// reply timing
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			bus_grant_out <= 1'b0;
			ack_out <= 1'b0;
			error_out <= 1'b0;
			wait_reg <= 4'h0;
			last_waddr_out <= '0;
			last_wdata_out <= '0;
			writes_out <= 8'h00;
		end else begin
			bus_grant_out <= bus_request_in;
			ack_out <= done_cycle && !fail;
			error_out <= done_cycle && fail;
			wait_reg <= (strobe_in && !done_cycle) ? wait_reg + 4'h1 : 4'h0;
			if (done_cycle && !fail && write_in) begin
				last_waddr_out <= addr_in;
				last_wdata_out <= wdata_in;
				writes_out <= writes_out + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ### dct_testbench.sv
// Purpose: self-checking bench for one dma channel
// Assumes: bus model answers with programmable wait and error
// Notes: function codes loaded as read 2, write 1
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import dct_pkg::*;
	localparam logic [5:0] M_RUN = 6'h01 << MODE_RUN_BIT;
	localparam logic [5:0] M_INT = 6'h01 << MODE_INTERNAL_BIT;
	localparam logic [5:0] M_NIRQ = 6'h01 << MODE_NIRQ_BIT;
	localparam logic [5:0] M_EIRQ = 6'h01 << MODE_EIRQ_BIT;
	localparam logic [5:0] M_INC = 6'h30;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic cfg_write = 1'b0;
	logic [1:0] cfg_sel = 2'h0;
	logic [23:0] cfg_data = 24'h000000;
	logic mode_write = 1'b0;
	logic [5:0] mode_data = 6'h00;
	logic [3:0] status_clear = 4'h0;
	logic xfer_request = 1'b0;
	logic done = 1'b0;
	logic [3:0] wait_cycles = 4'h0;
	logic fail_rd = 1'b0;
	logic fail_wr = 1'b0;
	logic ext_mode = 1'b0;
	logic xfer_ack, bus_request, bus_grant, strobe, bus_write, ack, berr, irq;
	logic [23:0] bus_addr, src, dst, count, last_waddr;
	logic [15:0] wdata, rdata, last_wdata;
	logic [2:0] fc;
	logic [5:0] mode, func;
	logic [3:0] status;
	logic [7:0] writes;
	int n_fail = 0;
	int n_compared = 0;
	int irq_count = 0;
	int strobe_count = 0;
	int req_count = 0;
	int irq_base;
	int write_base;
	always #2 clock_in = ~clock_in;
	dct_channel #(.ADDR_W(24), .DATA_W(16), .FIFO_DEPTH(8)) DUT (
		.clock_in(clock_in), .rst_in(rst_in), .cfg_write_in(cfg_write),
		.cfg_sel_in(cfg_sel), .cfg_data_in(cfg_data),
		.mode_write_in(mode_write), .mode_data_in(mode_data),
		.status_clear_in(status_clear), .xfer_request_in(xfer_request),
		.done_in(done), .xfer_acknowledge_out(xfer_ack),
		.bus_request_out(bus_request), .bus_grant_in(bus_grant),
		.bus_strobe_out(strobe), .bus_write_out(bus_write),
		.bus_addr_out(bus_addr), .bus_wdata_out(wdata),
		.bus_rdata_in(rdata), .data_transfer_ack(ack),
		.bus_error_in(berr), .bus_function_code_out(fc),
		.channel_mode_out(mode), .channel_status_out(status),
		.source_pointer_out(src), .dest_pointer_out(dst),
		.func_code_out(func), .byte_count_out(count),
		.irq_pending_set_out(irq));
	dct_bus_model #(.ADDR_W(24), .DATA_W(16)) model (
		.clock_in(clock_in), .rst_in(rst_in), .wait_in(wait_cycles),
		.fail_read_in(fail_rd), .fail_write_in(fail_wr),
		.bus_request_in(bus_request), .bus_grant_out(bus_grant),
		.strobe_in(strobe), .write_in(bus_write), .addr_in(bus_addr),
		.wdata_in(wdata), .rdata_out(rdata), .ack_out(ack),
		.error_out(berr), .last_waddr_out(last_waddr),
		.last_wdata_out(last_wdata), .writes_out(writes));
	// ==========================================================
	// compare and report
	task automatic check_val(input string what, input logic [31:0] exp,
		input logic [31:0] seen);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic check_flag(input string what, input logic exp,
		input logic seen);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic end_of_test;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ==========================================================
	// bus monitor
	always @(posedge clock_in) begin
		if (irq === 1'b1) irq_count++;
		if (bus_request === 1'b1) req_count++;
		if (strobe === 1'b1) begin
			strobe_count++;
			check_val("function code", bus_write ? 3'h1 : 3'h2, fc);
			check_flag("transfer acknowledge", ext_mode, xfer_ack);
		end
	end
	// ==========================================================
	// drivers
	task automatic load(input logic [1:0] sel, input logic [23:0] data);
		@(posedge clock_in);
		cfg_write <= 1'b1;
		cfg_sel <= sel;
		cfg_data <= data;
		@(posedge clock_in);
		cfg_write <= 1'b0;
	endtask
	task automatic set_mode(input logic [5:0] m);
		@(posedge clock_in);
		mode_write <= 1'b1;
		mode_data <= m;
		@(posedge clock_in);
		mode_write <= 1'b0;
	endtask
	task automatic run_op(input logic [23:0] s, d, n, input logic [5:0] m);
		@(posedge clock_in);
		status_clear <= 4'hf;
		@(posedge clock_in);
		status_clear <= 4'h0;
		load(SEL_SRC, s);
		load(SEL_DST, d);
		load(SEL_COUNT, n);
		irq_base = irq_count;
		write_base = writes;
		set_mode(m);
	endtask
	task automatic wait_stop(input int limit);
		int i;
		@(posedge clock_in);
		for (i = 0; i < limit && (mode[MODE_RUN_BIT] !== 1'b0 ||
			bus_request !== 1'b0); i++) @(posedge clock_in);
		if (i == limit) begin
			n_fail++;
			$display("ERROR channel stop expected 0 seen %b", mode[0]);
		end
		repeat (3) @(posedge clock_in);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset;
		check_val("function code reset", 6'h2d, func);
		check_val("mode reset", 6'h00, mode);
		check_val("status reset", 4'h0, status);
		check_val("count reset", 24'h0, count);
		load(SEL_FC, 24'h000011);
		@(posedge clock_in);
		check_val("function code load", 6'h11, func);
	endtask
	task automatic t_normal(input logic nirq);
		run_op(24'h100, 24'h200, 24'h4, M_RUN | M_INT | M_INC |
			(nirq ? M_NIRQ : 6'h00));
		wait_stop(400);
		check_val("count end", 24'h0, count);
		check_val("source end", 24'h104, src);
		check_val("dest end", 24'h204, dst);
		check_val("last write addr", 24'h202, last_waddr);
		check_val("last write data", 16'ha4c1, last_wdata);
		check_val("writes", 2, 32'(writes) - write_base);
		check_val("normal status", 4'h1, status);
		check_val("irq pulses", nirq, irq_count - irq_base);
	endtask
	task automatic t_term(input logic internal, input logic nirq);
		int base;
		@(posedge clock_in);
		ext_mode <= !internal;
		if (!internal) begin
			@(posedge clock_in);
			xfer_request <= 1'b1;
			base = req_count;
			repeat (20) @(posedge clock_in);
			check_val("idle requests", base, req_count);
		end
		done <= 1'b1;
		run_op(24'h100, 24'h200, 24'h8, M_RUN | M_INC |
			(internal ? M_INT : 6'h00) | (nirq ? M_NIRQ : 6'h00));
		wait_stop(400);
		done <= 1'b0;
		xfer_request <= 1'b0;
		check_val("count after term", 24'h6, count);
		check_val("source after term", 24'h102, src);
		check_val("dest after term", 24'h202, dst);
		check_val("term status", 4'h2, status);
		check_val("term irq", nirq, irq_count - irq_base);
		ext_mode <= 1'b0;
	endtask
	task automatic t_error(input logic on_write, input logic eirq);
		@(posedge clock_in);
		fail_rd <= !on_write;
		fail_wr <= on_write;
		run_op(24'h400, 24'h500, 24'h6, M_RUN | M_INT | M_INC |
			(eirq ? M_EIRQ : 6'h00));
		wait_stop(400);
		fail_rd <= 1'b0;
		fail_wr <= 1'b0;
		check_val("count after error", 24'h6, count);
		check_val("writes after error", 0, 32'(writes) - write_base);
		check_val("error status", on_write ? 4'h4 : 4'h8, status);
		check_val("error irq", eirq, irq_count - irq_base);
	endtask
	task automatic t_suspend;
		int i;
		int base;
		logic [23:0] saved;
		wait_cycles <= 4'h3;
		run_op(24'h100, 24'h300, 24'h10, M_RUN | M_INT | M_INC | M_NIRQ);
		for (i = 0; i < 200 && !(strobe === 1'b1 && bus_write === 1'b1); i++)
			@(posedge clock_in);
		load(SEL_SRC, 24'h0);
		set_mode(M_INT | M_INC | M_NIRQ);
		wait_stop(200);
		base = strobe_count;
		repeat (30) @(posedge clock_in);
		check_val("strobes while suspended", base, strobe_count);
		check_val("source plus count", 24'h110, src + count);
		check_val("dest minus source", 24'h200, dst - src);
		check_flag("suspended midway", 1'b1, count != 24'h0);
		saved = count;
		load(SEL_DST, 24'h800);
		@(posedge clock_in);
		check_val("dest while suspended", 24'h800, dst);
		set_mode(M_RUN | M_INT | M_INC | M_NIRQ);
		wait_stop(1000);
		check_val("count resumed", 24'h0, count);
		check_val("dest resumed", 24'h800 + saved, dst);
		check_val("resume last data", 16'ha4cd, last_wdata);
		check_val("resume status", 4'h1, status);
		wait_cycles <= 4'h0;
	endtask
	// ==========================================================
	// main sequence and watchdog
	initial begin
		repeat (12) @(posedge clock_in);
		rst_in <= 1'b0;
		t_reset();
		t_normal(1'b1);
		t_normal(1'b0);
		t_term(1'b0, 1'b1);
		t_term(1'b1, 1'b0);
		t_error(1'b0, 1'b1);
		t_error(1'b1, 1'b0);
		t_suspend();
		end_of_test();
	end
	initial begin
		#80000;
		n_fail++;
		$display("ERROR watchdog expected finish seen timeout");
		end_of_test();
	end
endmodule
`default_nettype wire
